// ### sewc_pkg.sv
// Shared constants and types of the serial word memory control block
package sewc_pkg;

	// ************************************************************
	// Array geometry
	// ************************************************************
	localparam int WORDS = 32;
	localparam int WORD_BITS = 32;
	localparam int ADDR_BITS = 5;
	localparam int FRAME_BITS = 12;

	// ************************************************************
	// Opcode encodings, first shifted bit on the left
	// ************************************************************
	localparam logic [2:0] OP_READ = 3'h0;
	localparam logic [2:0] OP_WORD_ERASE = 3'h2;
	localparam logic [2:0] OP_BLOCK_ERASE = 3'h6;
	localparam logic [2:0] OP_WRITE = 3'h4;
	localparam logic [2:0] OP_STANDBY = 3'h1;

	// ************************************************************
	// Reset values and erased word value
	// ************************************************************
	localparam logic [3:0] RST_CHIP = 4'h0;
	localparam logic [4:0] RST_WORD = 5'h00;
	localparam logic [31:0] RST_DATA = 32'h00000000;
	localparam logic [31:0] ERASED_WORD = 32'h00000000;

	// Address/opcode register, chip field shifted in first
	typedef struct packed {
		logic [3:0] chip;
		logic [4:0] word_address_bits;
		logic [2:0] op;
	} sewc_frame_t;

	// Decoded operation
	typedef enum logic [4:0] {
		SEWC_IDLE = 5'h01,
		SEWC_READ = 5'h02,
		SEWC_WERASE = 5'h04,
		SEWC_BERASE = 5'h08,
		SEWC_WRITE = 5'h10
	} sewc_op_t;

	// Open-drain / two-way pin drive pair
	typedef struct packed {
		logic out;
		logic oe_n;
	} sewc_pin_t;

endpackage : sewc_pkg

// ### sewc_serial_eeprom_word_control.sv
// Control logic of a 32-word by 32-bit serial electrically erasable memory
`timescale 1ns/1ps

module sewc_serial_eeprom_word_control #(
	parameter int WORDS = sewc_pkg::WORDS,
	parameter int WORD_BITS = sewc_pkg::WORD_BITS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic serial_clock,
	input wire logic shift_register_select,
	input wire logic serial_address_data_line_in,
	output logic serial_address_data_line_out,
	output logic serial_address_data_line_oe_n,
	input wire logic chip_identity_bit_first,
	input wire logic chip_identity_bit_2,
	input wire logic chip_identity_bit_3,
	input wire logic chip_identity_bit_last,
	input wire logic logic_supply_present,
	input wire logic program_supply_present,
	output logic program_voltage_control_out,
	output logic program_voltage_control_oe_n,
	output sewc_pkg::sewc_op_t active_op
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic sewc_pkg::sewc_op_t decode_op(input logic [2:0] op);
		sewc_pkg::sewc_op_t res;
		res = sewc_pkg::SEWC_IDLE;
		if (op[0] == 1'b1)
		begin
			res = sewc_pkg::SEWC_IDLE;
		end
		else
		begin
			case (op)
				sewc_pkg::OP_READ: res = sewc_pkg::SEWC_READ;
				sewc_pkg::OP_WORD_ERASE: res = sewc_pkg::SEWC_WERASE;
				sewc_pkg::OP_BLOCK_ERASE: res = sewc_pkg::SEWC_BERASE;
				sewc_pkg::OP_WRITE: res = sewc_pkg::SEWC_WRITE;
				default: res = sewc_pkg::SEWC_IDLE;
			endcase
		end
		return res;
	endfunction : decode_op

	// Output stays off for the single cycle that select has just fallen, so the first bit is valid
	function automatic logic loaded_or_loading(input logic sel_prev);
		return ~sel_prev;
	endfunction : loaded_or_loading

	// ************************************************************
	// State
	// ************************************************************
	sewc_pkg::sewc_frame_t frame_r;
	sewc_pkg::sewc_frame_t frame_nxt;
	logic [WORD_BITS-1:0] data_r;
	logic [WORD_BITS-1:0] data_nxt;
	logic sclk_r;
	logic sclk_nxt;
	logic sel_r;
	logic sel_nxt;
	logic loaded_r;
	logic loaded_nxt;
	logic [WORD_BITS-1:0] mem_r [WORDS];
	logic [WORD_BITS-1:0] mem_nxt [WORDS];
	sewc_pkg::sewc_op_t op_now;

	logic sclk_fall;
	logic chip_match;
	logic [3:0] identity;

	assign identity = {chip_identity_bit_first, chip_identity_bit_2, chip_identity_bit_3, chip_identity_bit_last};
	// Serial clock pins are sampled as synchronous levels; edges come from the last sample
	assign sclk_fall = sclk_r & ~serial_clock;
	assign chip_match = (frame_r.chip == identity);

	// ************************************************************
	// Instruction decode
	// ************************************************************
	always_comb
	begin
		op_now = sewc_pkg::SEWC_IDLE;
		if (!shift_register_select && chip_match)
		begin
			op_now = decode_op(frame_r.op);
		end
	end

	// ************************************************************
	// Shift registers and read transfer
	// ************************************************************
	always_comb
	begin
		frame_nxt = frame_r;
		data_nxt = data_r;
		sclk_nxt = serial_clock;
		sel_nxt = shift_register_select;
		loaded_nxt = loaded_r;
		if (shift_register_select)
		begin
			loaded_nxt = 1'b0;
			if (sclk_fall)
			begin
				// Chip field enters first and ends up in the top bits
				frame_nxt = sewc_pkg::sewc_frame_t'({frame_r[sewc_pkg::FRAME_BITS-2:0],
					serial_address_data_line_in});
			end
		end
		else if (op_now == sewc_pkg::SEWC_READ)
		begin
			if (sclk_fall)
			begin
				// Word recirculates so a second pass reads it again
				loaded_nxt = 1'b1;
				data_nxt = {data_r[0], data_r[WORD_BITS-1:1]};
			end
			else if (!loaded_r)
			begin
				// Parallel transfer runs until the first clock falls
				data_nxt = mem_r[frame_r.word_address_bits];
			end
		end
		else if (sclk_fall)
		begin
			data_nxt = {serial_address_data_line_in, data_r[WORD_BITS-1:1]};
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			frame_r <= '{chip: sewc_pkg::RST_CHIP, word_address_bits: sewc_pkg::RST_WORD,
				op: sewc_pkg::OP_STANDBY};
			data_r <= sewc_pkg::RST_DATA;
			sclk_r <= 1'b0;
			sel_r <= 1'b1;
			loaded_r <= 1'b0;
		end
		else
		begin
			frame_r <= frame_nxt;
			data_r <= data_nxt;
			sclk_r <= sclk_nxt;
			sel_r <= sel_nxt;
			loaded_r <= loaded_nxt;
		end
	end

	// ************************************************************
	// Array erase and program
	// ************************************************************
	// Erase and write act for as long as select stays low; the controller times them
	always_comb
	begin
		for (int i = 0; i < WORDS; i++)
		begin
			mem_nxt[i] = mem_r[i];
		end
		if (program_supply_present && logic_supply_present)
		begin
			case (op_now)
				sewc_pkg::SEWC_WERASE:
				begin
					mem_nxt[frame_r.word_address_bits] = sewc_pkg::ERASED_WORD;
				end
				sewc_pkg::SEWC_BERASE:
				begin
					for (int i = 0; i < WORDS; i++)
					begin
						mem_nxt[i] = sewc_pkg::ERASED_WORD;
					end
				end
				sewc_pkg::SEWC_WRITE:
				begin
					// Programming only sets bits, hence the erase beforehand
					mem_nxt[frame_r.word_address_bits] = mem_r[frame_r.word_address_bits] | data_r;
				end
				default:
				begin
					mem_nxt[0] = mem_r[0];
				end
			endcase
		end
	end

	// Nonvolatile contents survive reset
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < WORDS; i++)
		begin
			mem_r[i] <= mem_nxt[i];
		end
	end

	// ************************************************************
	// Pins
	// ************************************************************
	sewc_pkg::sewc_pin_t adq_pin;
	sewc_pkg::sewc_pin_t pvc_pin;

	always_comb
	begin
		adq_pin.out = data_r[0];
		adq_pin.oe_n = ~((op_now == sewc_pkg::SEWC_READ) && loaded_or_loading(sel_r));
		pvc_pin.out = 1'b0;
		pvc_pin.oe_n = ~(logic_supply_present && ((op_now == sewc_pkg::SEWC_WERASE)
			|| (op_now == sewc_pkg::SEWC_BERASE) || (op_now == sewc_pkg::SEWC_WRITE)));
	end

	assign serial_address_data_line_out = adq_pin.out;
	assign serial_address_data_line_oe_n = adq_pin.oe_n;
	assign program_voltage_control_out = pvc_pin.out;
	assign program_voltage_control_oe_n = pvc_pin.oe_n;
	assign active_op = op_now;

endmodule : sewc_serial_eeprom_word_control

// ### sewc_monitor.sv
// Port assertions for the serial word memory control block
`timescale 1ns/1ps

module sewc_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic serial_clock,
	input wire logic shift_register_select,
	input wire logic logic_supply_present,
	input wire logic serial_address_data_line_out,
	input wire logic serial_address_data_line_oe_n,
	input wire logic program_voltage_control_out,
	input wire logic program_voltage_control_oe_n,
	input wire sewc_pkg::sewc_op_t active_op
);
	// ********
	// Short aliases
	// ********
	wire oe = serial_address_data_line_oe_n;
	wire pv = program_voltage_control_oe_n;
	wire sel = shift_register_select;
	wire sck = serial_clock;
	wire pgm = |active_op[4:2];

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_drive_cause: assert property (!oe |-> active_op == sewc_pkg::SEWC_READ && !sel)
		else $error("output driven outside a read");
	chk_read_drives: assert property (active_op == sewc_pkg::SEWC_READ && $past(active_op) == sewc_pkg::SEWC_READ |-> !oe)
		else $error("read decoded but output released");
	chk_sel_idle: assert property (sel |-> active_op == sewc_pkg::SEWC_IDLE)
		else $error("operation decoded with select high");
	chk_pvc_cause: assert property (!pv |-> logic_supply_present && !sel && pgm)
		else $error("voltage control on without cause");
	chk_pvc_on: assert property (pgm && logic_supply_present |-> !pv)
		else $error("voltage control off during erase or write");
	chk_pvc_low: assert property (!pv |-> !program_voltage_control_out)
		else $error("voltage control drives high");
	// Output moves only one cycle after a detected falling serial edge
	chk_shift_edge: assert property (!oe && $past(!oe) && $changed(serial_address_data_line_out) |-> $past(sck, 2) && !$past(sck))
		else $error("output moved without a falling serial edge");
	chk_op_onehot: assert property ($onehot(active_op))
		else $error("decoded operation not one-hot");

	cover property (!oe && $past(sck) && !sck);
	cover property (!pv && active_op[3]);
	cover property (!pv && active_op[4]);
endmodule : sewc_monitor

bind sewc_serial_eeprom_word_control sewc_monitor mon (
	.clk(clk),
	.rst(rst),
	.serial_clock(serial_clock),
	.shift_register_select(shift_register_select),
	.logic_supply_present(logic_supply_present),
	.serial_address_data_line_out(serial_address_data_line_out),
	.serial_address_data_line_oe_n(serial_address_data_line_oe_n),
	.program_voltage_control_out(program_voltage_control_out),
	.program_voltage_control_oe_n(program_voltage_control_oe_n),
	.active_op(active_op)
);

// ### sewc_host.sv
// Host controller model driving serial clock, select and data lines
`timescale 1ns/1ps

module sewc_host (
	input wire logic clk,
	input wire logic out,
	output logic sck,
	output logic sel,
	output logic din,
	output logic vpp
);
	initial
	begin
		sck = 1'b0;
		sel = 1'b1;
		din = 1'b0;
		vpp = 1'b0;
	end

	// One bit: present, clock high, sample, then fall
	task bit_io(input logic b, output logic q);
		@(posedge clk);
		din <= b;
		sck <= 1'b1;
		@(negedge clk);
		q = out;
		@(posedge clk);
		sck <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : bit_io

	// Frame is shifted with select high, then select is held low to act
	task frame(input sewc_pkg::sewc_frame_t f);
		logic q;
		@(posedge clk);
		sel <= 1'b1;
		vpp <= f.op != 3'h0 && !f.op[0];
		for (int i = 11; i >= 0; i--)
			bit_io(f[i], q);
		@(posedge clk);
		sel <= 1'b0;
		repeat (4) @(posedge clk);
		// Hand back off the edge so callers look at settled outputs
		@(negedge clk);
	endtask : frame

	task put(input logic [31:0] d);
		logic q;
		for (int i = 0; i < 32; i++)
			bit_io(d[i], q);
	endtask : put

	// Input line is not used while reading, so the driven value toggles
	task get(output logic [31:0] d);
		for (int i = 0; i < 32; i++)
			bit_io(!din, d[i]);
	endtask : get
endmodule : sewc_host

// ### tb_serial_eeprom_word_control.sv
// Self-checking bench for the serial word memory control block
`timescale 1ns/1ps

module tb_serial_eeprom_word_control;
	localparam logic [3:0] ID = 4'hA;
	localparam logic [31:0] DW = 32'hC3A50F96;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic serial_clock;
	logic shift_register_select;
	logic serial_address_data_line_in;
	logic serial_address_data_line_out;
	logic serial_address_data_line_oe_n;
	logic chip_identity_bit_first = ID[3];
	logic chip_identity_bit_2 = ID[2];
	logic chip_identity_bit_3 = ID[1];
	logic chip_identity_bit_last = ID[0];
	logic logic_supply_present = 1'b1;
	logic program_supply_present;
	logic program_voltage_control_out;
	logic program_voltage_control_oe_n;
	sewc_pkg::sewc_op_t active_op;
	int err_count = 0;
	int compares = 0;
	logic adq_seen;

	// A released line shows the inverse of the last bit, so a read with the output off cannot pass
	assign adq_seen = serial_address_data_line_oe_n ? ~serial_address_data_line_out : serial_address_data_line_out;

	sewc_serial_eeprom_word_control dut (
		.clk(clk),
		.rst(rst),
		.serial_clock(serial_clock),
		.shift_register_select(shift_register_select),
		.serial_address_data_line_in(serial_address_data_line_in),
		.serial_address_data_line_out(serial_address_data_line_out),
		.serial_address_data_line_oe_n(serial_address_data_line_oe_n),
		.chip_identity_bit_first(chip_identity_bit_first),
		.chip_identity_bit_2(chip_identity_bit_2),
		.chip_identity_bit_3(chip_identity_bit_3),
		.chip_identity_bit_last(chip_identity_bit_last),
		.logic_supply_present(logic_supply_present),
		.program_supply_present(program_supply_present),
		.program_voltage_control_out(program_voltage_control_out),
		.program_voltage_control_oe_n(program_voltage_control_oe_n),
		.active_op(active_op)
	);
	sewc_host host (.clk(clk), .out(adq_seen), .sck(serial_clock),
		.sel(shift_register_select), .din(serial_address_data_line_in), .vpp(program_supply_present));

	always #4 clk = ~clk;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask : chk

	task finish_test();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	// ********
	// Erase, write, protect and read back
	// ********
	initial
	begin
		logic [31:0] w;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(active_op, sewc_pkg::SEWC_IDLE);
		chk(serial_address_data_line_oe_n, 1'b1);
		host.frame({ID, 5'h05, sewc_pkg::OP_WORD_ERASE});
		chk(program_voltage_control_oe_n, 1'b0);
		chk(program_voltage_control_out, 1'b0);
		@(posedge clk);
		logic_supply_present <= 1'b0;
		@(negedge clk);
		chk(program_voltage_control_oe_n, 1'b1);
		@(posedge clk);
		logic_supply_present <= 1'b1;
		host.put(DW);
		host.frame({ID, 5'h05, sewc_pkg::OP_WRITE});
		chk(active_op, sewc_pkg::SEWC_WRITE);
		host.frame({ID, 5'h05, sewc_pkg::OP_STANDBY});
		chk(program_voltage_control_oe_n, 1'b1);
		host.frame({~ID, 5'h05, sewc_pkg::OP_WORD_ERASE});
		chk(program_voltage_control_oe_n, 1'b1);
		host.frame({ID, 5'h05, sewc_pkg::OP_READ});
		chk(serial_address_data_line_oe_n, 1'b0);
		host.get(w);
		chk(w, DW);
		host.frame({ID, 5'h00, sewc_pkg::OP_BLOCK_ERASE});
		chk(active_op, sewc_pkg::SEWC_BERASE);
		host.frame({ID, 5'h05, sewc_pkg::OP_READ});
		host.get(w);
		chk(w, sewc_pkg::ERASED_WORD);
		finish_test();
	end

	initial
	begin
		#20000;
		err_count++;
		finish_test();
	end
endmodule : tb_serial_eeprom_word_control
